// File: dv/wdit_top_tb.sv
// self-checking bench for the watchdog interval timer top
// assumes the design files under logic/ are compiled before it
`define CHK(got, exp, msg) begin n_tests++; if ((got) !== (exp)) begin fail_count++; $display("[FAIL] %0t %s", $time, msg); end end
module wdit_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk_sys = 1'b0;
  logic       reset_n = 1'b0;
  logic       timer_enable = 1'b0;
  logic       watchdog_mode = 1'b0;
  logic       reset_select = 1'b0;
  logic [2:0] sel = 3'h0;
  logic       flag_read = 1'b0;
  logic       flag_write_zero = 1'b0;
  logic [7:0] watchdog_count;
  logic       overflow_flag;
  logic       overflow_irq;
  logic       nmi_request;
  logic       reset_request;
  logic [2:0] exp_q[$];
  logic [7:0] r = 8'h37;
  int         fail_count = 0;
  int         n_tests = 0;
  int         seen = 0;
  int         cycles = 0;
  int         divs[8] = '{2, 32, 64, 128, 256, 512, 2048, 4096};

  wdit_top uut (.clk_sys(clk_sys), .reset_n(reset_n), .timer_enable(timer_enable),
    .watchdog_mode(watchdog_mode), .reset_select(reset_select), .prescale_select_bit2(sel[2]),
    .prescale_select_bit1(sel[1]), .prescale_select_bit0(sel[0]), .flag_read(flag_read),
    .flag_write_zero(flag_write_zero), .watchdog_count(watchdog_count), .overflow_flag(overflow_flag),
    .overflow_irq(overflow_irq), .nmi_request(nmi_request), .reset_request(reset_request));

  // 100 MHz clock
  always #5 clk_sys = ~clk_sys;

  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // flag access: a read and/or a zero write; with both, the write follows the read on the next cycle
  task automatic flag_access(input logic rd, input logic wr);
    flag_read <= rd;
    flag_write_zero <= wr && !rd;
    @(posedge clk_sys);
    flag_read <= 1'b0;
    flag_write_zero <= rd && wr;
    @(posedge clk_sys);
    flag_write_zero <= 1'b0;
    @(posedge clk_sys);
  endtask

  // measure the spacing of count steps for one divider code
  task automatic div_check(input logic [2:0] c, input int d);
    int n;
    n = 0;
    sel <= c;
    timer_enable <= 1'b1;
    for (int i = 0; i < 9000 && watchdog_count !== 8'h01; i++) @(posedge clk_sys);
    while (watchdog_count === 8'h01 && n < 9000) begin
      @(posedge clk_sys);
      n++;
    end
    `CHK(n, d, "tick period")
    `CHK(watchdog_count, 8'h02, "count step")
    timer_enable <= 1'b0;
    repeat (2) @(posedge clk_sys);
    `CHK(watchdog_count, 8'h00, "count not cleared")
  endtask

  // run to one wrap at the fastest divider and note the request kind
  task automatic run_ovf(input logic m, input logic rs);
    int s0;
    s0 = seen;
    watchdog_mode <= m;
    reset_select <= rs;
    sel <= 3'h0;
    timer_enable <= 1'b1;
    exp_q.push_back(m ? (rs ? 3'b001 : 3'b010) : 3'b100);
    for (int i = 0; i < 700 && seen == s0; i++) @(posedge clk_sys);
    `CHK(seen, s0 + 1, "no overflow request")
    `CHK(overflow_flag, 1'b1, "flag not set")
    timer_enable <= 1'b0;
    @(posedge clk_sys);
  endtask

  // watch request pulses and match each against the oldest note
  always @(posedge clk_sys) begin
    if (reset_n && ((|{overflow_irq, nmi_request, reset_request}) === 1'b1)) begin
      if (exp_q.size() == 0) begin
        fail_count++;
        $display("[FAIL] %0t unexpected request", $time);
      end else
        `CHK({overflow_irq, nmi_request, reset_request}, exp_q.pop_front(), "request kind")
      `CHK(watchdog_count, 8'h00, "no wrap at request")
      seen <= seen + 1;
    end
  end

  // hang guard
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      fail_count++;
      $display("[FAIL] %0t timeout", $time);
      summarize();
    end
  end

  // main sequence
  initial begin
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    `CHK(watchdog_count, 8'h00, "count after reset")
    `CHK(overflow_flag, 1'b0, "flag after reset")
    for (int c = 0; c < 8; c++) div_check(c[2:0], divs[c]);
    $display("dividers done");
    for (int i = 0; i < 6; i++) begin
      r = lfsr(r);
      if (i < 4)
        run_ovf(i[1], i[0]);
      else
        run_ovf(r[0], r[1]);
    end
    $display("overflow kinds done");
    flag_access(1'b0, 1'b1);
    `CHK(overflow_flag, 1'b1, "write without read cleared")
    flag_access(1'b1, 1'b0);
    flag_access(1'b0, 1'b1);
    `CHK(overflow_flag, 1'b0, "read then write kept flag")
    flag_access(1'b1, 1'b0);
    run_ovf(1'b0, 1'b0);
    flag_access(1'b0, 1'b1);
    `CHK(overflow_flag, 1'b1, "read of clear flag armed")
    flag_access(1'b1, 1'b1);
    `CHK(overflow_flag, 1'b0, "back to back clear kept flag")
    $display("flag clear done");
    summarize();
  end
endmodule

// File: logic/wdit_map.svh
// constants for the watchdog interval timer
// assumes inclusion by the timer modules only
`ifndef WDIT_MAP_SVH
`define WDIT_MAP_SVH
// prescaler division exponents for select codes 0..7 (2,32,64,128,256,512,2048,4096)
`define WDIT_DIV_EXP0 4'h1
`define WDIT_DIV_EXP1 4'h5
`define WDIT_DIV_EXP2 4'h6
`define WDIT_DIV_EXP3 4'h7
`define WDIT_DIV_EXP4 4'h8
`define WDIT_DIV_EXP5 4'h9
`define WDIT_DIV_EXP6 4'hB
`define WDIT_DIV_EXP7 4'hC
// reset values and count maximum
`define WDIT_RST_SELECT 3'h0
`define WDIT_RST_COUNT  8'h00
`define WDIT_COUNT_MAX  8'hFF
// prescaler width: enough for the largest division
`define WDIT_PRE_WIDTH  12
`endif

// File: logic/wdit_pkg.sv
// types for the watchdog interval timer
// assumes wdit_map.svh is on the include path
package wdit_pkg;
  // overflow clear handshake state
  typedef enum logic [1:0] {
    WDIT_CLR_IDLE  = 2'b00,
    WDIT_CLR_ARMED = 2'b01
  } wdit_clr_state_t;
endpackage

// File: logic/wdit_prescaler.sv
// prescaler, held at zero while run is low, producing one-cycle count ticks
// assumes clk_sys is the peripheral clock
`include "wdit_map.svh"
module wdit_prescaler #(
  parameter int PRE_WIDTH = `WDIT_PRE_WIDTH
) (
  // clock and reset
  input  wire logic                clk_sys,
  input  wire logic                reset_n,
  // control
  input  wire logic                run,
  input  wire logic [2:0]          select,
  // tick out
  output logic                     tick
);
  logic [PRE_WIDTH-1:0] pre;
  logic [PRE_WIDTH-1:0] next_pre;
  logic                 next_tick;

  // elaboration check: the largest division needs twelve bits
  if (PRE_WIDTH < 12) begin
    $error("prescaler too narrow");
  end

  // decode select into division exponent
  function automatic logic [3:0] wdit_exp(input logic [2:0] s);
    case (s)
      3'h0: wdit_exp = `WDIT_DIV_EXP0;
      3'h1: wdit_exp = `WDIT_DIV_EXP1;
      3'h2: wdit_exp = `WDIT_DIV_EXP2;
      3'h3: wdit_exp = `WDIT_DIV_EXP3;
      3'h4: wdit_exp = `WDIT_DIV_EXP4;
      3'h5: wdit_exp = `WDIT_DIV_EXP5;
      3'h6: wdit_exp = `WDIT_DIV_EXP6;
      default: wdit_exp = `WDIT_DIV_EXP7;
    endcase
  endfunction

  // count and fire when low bits reach all ones
  always_comb begin
    logic [PRE_WIDTH-1:0] mask;
    mask = (PRE_WIDTH'(1) << wdit_exp(select)) - PRE_WIDTH'(1);
    next_pre  = run ? pre + PRE_WIDTH'(1) : '0;
    next_tick = run && ((pre & mask) == mask);
  end

  // register
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pre  <= '0;
      tick <= 1'b0;
    end else begin
      pre  <= next_pre;
      tick <= next_tick;
    end
  end
endmodule

// File: logic/wdit_top.sv
// watchdog / interval timer top: counter, overflow flag, request outputs
// assumes control bits arrive as synchronous ports from a register file
`include "wdit_map.svh"
module wdit_top #(
  parameter int COUNT_WIDTH = 8
) (
  // clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   reset_n,
  // control bits
  input  wire logic                   timer_enable,
  input  wire logic                   watchdog_mode,
  input  wire logic                   reset_select,
  input  wire logic                   prescale_select_bit2,
  input  wire logic                   prescale_select_bit1,
  input  wire logic                   prescale_select_bit0,
  // overflow flag access
  input  wire logic                   flag_read,
  input  wire logic                   flag_write_zero,
  // status
  output logic [COUNT_WIDTH-1:0]      watchdog_count,
  output logic                        overflow_flag,
  // requests, one-cycle pulses
  output logic                        overflow_irq,
  output logic                        nmi_request,
  output logic                        reset_request
);
  logic                       tick;
  logic                       wrap;
  logic [COUNT_WIDTH-1:0]     next_count;
  logic                       next_flag;
  logic                       next_irq;
  logic                       next_nmi;
  logic                       next_rst;
  wdit_pkg::wdit_clr_state_t  clr_state;
  wdit_pkg::wdit_clr_state_t  next_clr_state;

  // elaboration check: the wrap and flag logic serve an eight-bit counter only
  if (COUNT_WIDTH != 8) begin
    $error("counter must be eight bits");
  end

  // tick generator
  wdit_prescaler #(
    .PRE_WIDTH (`WDIT_PRE_WIDTH)
  ) u_pre (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .run     (timer_enable),
    .select  ({prescale_select_bit2, prescale_select_bit1, prescale_select_bit0}),
    .tick    (tick)
  );

  // counter and wrap detection
  always_comb begin
    wrap = timer_enable && tick && (watchdog_count == `WDIT_COUNT_MAX);
    if (!timer_enable) begin
      next_count = `WDIT_RST_COUNT;
    end else if (tick) begin
      next_count = watchdog_count + COUNT_WIDTH'(1);
    end else begin
      next_count = watchdog_count;
    end
  end

  // request routing by mode
  always_comb begin
    next_irq = wrap && !watchdog_mode;
    next_nmi = wrap && watchdog_mode && !reset_select;
    next_rst = wrap && watchdog_mode && reset_select;
  end

  // flag with read-then-write-zero clear; set wins
  always_comb begin
    next_clr_state = clr_state;
    next_flag      = overflow_flag;
    case (clr_state)
      wdit_pkg::WDIT_CLR_IDLE: begin
        if (flag_read && overflow_flag) begin
          next_clr_state = wdit_pkg::WDIT_CLR_ARMED;
        end
      end
      wdit_pkg::WDIT_CLR_ARMED: begin
        if (flag_write_zero) begin
          next_flag      = 1'b0;
          next_clr_state = wdit_pkg::WDIT_CLR_IDLE;
        end
      end
      default: next_clr_state = wdit_pkg::WDIT_CLR_IDLE;
    endcase
    if (wrap) begin
      next_flag = 1'b1;
    end
  end

  // count register
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      watchdog_count <= `WDIT_RST_COUNT;
    end else begin
      watchdog_count <= next_count;
    end
  end

  // request registers, so every request leaves a flip-flop
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      overflow_irq  <= 1'b0;
      nmi_request   <= 1'b0;
      reset_request <= 1'b0;
    end else begin
      overflow_irq  <= next_irq;
      nmi_request   <= next_nmi;
      reset_request <= next_rst;
    end
  end

  // flag and clear handshake registers
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      overflow_flag <= 1'b0;
      clr_state     <= wdit_pkg::WDIT_CLR_IDLE;
    end else begin
      overflow_flag <= next_flag;
      clr_state     <= next_clr_state;
    end
  end

  // count clock period in system clocks for a select code
  function automatic logic [12:0] wdit_period(input logic [2:0] s);
    case (s)
      3'h0: wdit_period = 13'h0001 << `WDIT_DIV_EXP0;
      3'h1: wdit_period = 13'h0001 << `WDIT_DIV_EXP1;
      3'h2: wdit_period = 13'h0001 << `WDIT_DIV_EXP2;
      3'h3: wdit_period = 13'h0001 << `WDIT_DIV_EXP3;
      3'h4: wdit_period = 13'h0001 << `WDIT_DIV_EXP4;
      3'h5: wdit_period = 13'h0001 << `WDIT_DIV_EXP5;
      3'h6: wdit_period = 13'h0001 << `WDIT_DIV_EXP6;
      default: wdit_period = 13'h0001 << `WDIT_DIV_EXP7;
    endcase
  endfunction

  // checker state: cycles since the last tick and the setting it ran at
  logic [12:0] tick_gap;
  logic [12:0] next_tick_gap;
  logic        gap_valid;
  logic        next_gap_valid;
  logic [2:0]  select_prev;
  logic [2:0]  next_select_prev;

  // gap count; valid only after a tick with enable and select steady since
  always_comb begin
    next_select_prev = {prescale_select_bit2, prescale_select_bit1, prescale_select_bit0};
    next_tick_gap    = tick ? 13'h0001 : tick_gap;
    if (!tick && tick_gap != 13'h1FFF) begin
      next_tick_gap = tick_gap + 13'h0001; // saturates, never wraps
    end
    next_gap_valid = timer_enable && (next_select_prev == select_prev) && (tick || gap_valid);
  end

  // checker state registers
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tick_gap    <= 13'h0000;
      gap_valid   <= 1'b0;
      select_prev <= `WDIT_RST_SELECT;
    end else begin
      tick_gap    <= next_tick_gap;
      gap_valid   <= next_gap_valid;
      select_prev <= next_select_prev;
    end
  end

  // checks
  sequence wdit_wrap_s;
    timer_enable && tick && watchdog_count == 8'hFF;
  endsequence

  // first step of a clear: a read that sees the flag set, no write alongside
  sequence wdit_read_set_s;
    flag_read && overflow_flag && !flag_write_zero;
  endsequence

  // second step of a clear: a zero write with no wrap racing it
  sequence wdit_zero_write_s;
    flag_write_zero && !wrap;
  endsequence

  tick_period_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    gap_valid |-> (tick == (tick_gap == wdit_period(select_prev)))) else $error("tick period wrong");
  tick_stop_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !timer_enable |=> !tick) else $error("tick while stopped");
  no_wrap_quiet_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !wrap |=> !overflow_irq && !nmi_request && !reset_request) else $error("request without overflow");
  flag_hold_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !overflow_flag && !wrap |=> !overflow_flag) else $error("flag set without wrap");
  arm_guard_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    clr_state == wdit_pkg::WDIT_CLR_IDLE && !(flag_read && overflow_flag) |=> clr_state == wdit_pkg::WDIT_CLR_IDLE)
    else $error("clear armed without read of set flag");

  stopped_zero_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !timer_enable |=> watchdog_count == 8'h00) else $error("count not held at zero");
  count_step_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    timer_enable && tick |=> watchdog_count == $past(watchdog_count) + 8'h01) else $error("count step wrong");
  count_hold_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    timer_enable && !tick |=> $stable(watchdog_count)) else $error("count moved without tick");
  flag_set_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    wdit_wrap_s |=> overflow_flag && watchdog_count == 8'h00) else $error("flag not set on wrap");
  interval_irq_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    wdit_wrap_s ##0 !watchdog_mode |=> overflow_irq && !nmi_request && !reset_request) else $error("interval bad");
  watchdog_route_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    wdit_wrap_s ##0 watchdog_mode |=> (reset_request == $past(reset_select)) && (nmi_request != $past(reset_select)))
    else $error("watchdog route bad");
  clear_guard_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    overflow_flag && clr_state == wdit_pkg::WDIT_CLR_IDLE |=> overflow_flag) else $error("flag cleared without read");
  clear_done_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    wdit_read_set_s ##1 wdit_zero_write_s |=> !overflow_flag) else $error("flag clear failed");
  tick_rate_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    timer_enable && {prescale_select_bit2, prescale_select_bit1, prescale_select_bit0} == 3'h0 && tick
    ##1 timer_enable && {prescale_select_bit2, prescale_select_bit1, prescale_select_bit0} == 3'h0
    |-> !tick ##1 tick) else $error("divide by two rate wrong");
endmodule
